/* File: hdl/sm_pkg.sv */
// shared constants for the synchronous master serial port
package sm_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_RX_CTRL   = 8'h18;
  localparam logic [7:0] IDX_TX_BUF    = 8'h19;
  localparam logic [7:0] IDX_RX_BUF    = 8'h1A;
  localparam logic [7:0] IDX_IRQ_EN    = 8'h8C;
  localparam logic [7:0] IDX_TX_CTRL   = 8'h98;
  localparam logic [7:0] IDX_BAUD      = 8'h99;

  // ----------------------------------------------------------------
  // receive_status_control fields
  // ----------------------------------------------------------------
  localparam int POS_PORT_EN     = 7;
  localparam int POS_NINTH_RX_SEL = 6;
  localparam int POS_SINGLE_RX   = 5;
  localparam int POS_CONT_RX     = 4;
  localparam int POS_OVERRUN     = 1;
  localparam int POS_RX_NINTH    = 0;
  localparam logic [7:0] RX_CTRL_WMASK = 8'hF0;

  // ----------------------------------------------------------------
  // transmit_status_control fields
  // ----------------------------------------------------------------
  localparam int POS_CLK_SRC      = 7;
  localparam int POS_NINTH_TX_SEL = 6;
  localparam int POS_TX_EN        = 5;
  localparam int POS_SYNC_MODE    = 4;
  localparam int POS_SHIFT_EMPTY  = 1;
  localparam int POS_TX_NINTH     = 0;
  localparam logic [7:0] TX_CTRL_WMASK = 8'hF5;

  // ----------------------------------------------------------------
  // peripheral_irq_flags fields, word sizes
  // ----------------------------------------------------------------
  localparam int POS_RX_FLAG = 5;
  localparam int POS_TX_FLAG = 4;
  localparam logic [3:0] WORD_BITS_8 = 4'h8;
  localparam logic [3:0] WORD_BITS_9 = 4'h9;
  localparam int WORD_W   = 9;
  localparam int RX_DEPTH = 2;
  localparam int BAUD_W   = 8;

endpackage

/* File: hdl/baud_generator.sv */
// shift-clock phase tick generator, held in reset while idle
`timescale 1ns/100ps
`default_nettype none

module baud_generator #(
  parameter int W = 8
) (
  // system
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] divisor,
  // one pulse per half shift-clock period
  output logic              tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } brg_t;

  brg_t brg_q;
  brg_t brg_d;

  assign tick = brg_q.tick;

  always_comb
  begin
    brg_d      = brg_q;
    brg_d.tick = 1'b0;
    if (!run)
      brg_d.cnt = '0;
    else if (brg_q.cnt == divisor)
    begin
      brg_d.cnt  = '0;
      brg_d.tick = 1'b1;
    end
    else
      brg_d.cnt = brg_q.cnt + W'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      brg_q <= '0;
    else
      brg_q <= brg_d;
  end

endmodule

`default_nettype wire

/* File: hdl/rx_fifo.sv */
// small receive FIFO, first word in is first word out
`timescale 1ns/100ps
`default_nettype none

module rx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // system
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             push_valid,
  input  wire logic [WIDTH-1:0] push_data,
  output logic                  push_ready,
  // drain side
  input  wire logic             pop,
  output logic                  head_valid,
  output logic      [WIDTH-1:0] head_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } fifo_t;

  fifo_t fifo_q;
  fifo_t fifo_d;

  assign push_ready = (fifo_q.cnt != FULL);
  assign head_valid = (fifo_q.cnt != '0);
  assign head_data  = fifo_q.mem[fifo_q.rd];

  always_comb
  begin
    logic do_push;
    logic do_pop;
    do_push = push_valid & push_ready;
    do_pop  = pop & head_valid;
    fifo_d  = fifo_q;
    if (do_push)
    begin
      fifo_d.mem[fifo_q.wr] = push_data;
      fifo_d.wr = (fifo_q.wr == LAST) ? '0 : fifo_q.wr + PW'(1);
    end
    if (do_pop)
      fifo_d.rd = (fifo_q.rd == LAST) ? '0 : fifo_q.rd + PW'(1);
    if (do_push && !do_pop)
      fifo_d.cnt = fifo_q.cnt + CW'(1);
    else if (do_pop && !do_push)
      fifo_d.cnt = fifo_q.cnt - CW'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      fifo_q <= '0;
    else
      fifo_q <= fifo_d;
  end

endmodule

`default_nettype wire

/* File: hdl/usart_sync_master.sv */
// synchronous master serial port: registers, shifters and pin control
// What this block does
// - Transmit and receive never run together.
// - Sync, port enable, clock source and an enable claim clock; transmit claims data.
// - Clock source bit makes us drive clock.
// - Shifter loads from buffer after last bit.
// - Transmit flag clears on buffer write or transmit enable clear.
// - Shifter empty bit is read-only status.
// - Shifting needs enable plus buffered word.
// - Data changes on rise, stable at fall.
// - Baud generator held while enables clear.
// - Dropping transmit enable resets, floats pins.
// - Receive enable pauses transmit, clock stays driven.
// - Single receive self-clears, transmit then resumes.
// - Ninth bit taken at shifter load.
// - Either receive enable starts; sample on fall.
// - Single takes one word; continuous wins.
// - Finished word enters FIFO, sets receive flag.
// - Receive flag clears when FIFO empties.
// - Two-entry FIFO read out in order.
// - Full FIFO at word end sets overrun.
// - Overrun blocks pushes; continuous clear clears it.
// - Ninth bit travels with each FIFO word.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module usart_sync_master (
  // system
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // register bus
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // serial clock line
  output logic             serial_clock_line_o,
  output logic             serial_clock_line_oe_n,
  // serial data line
  input  wire logic        serial_data_line_i,
  output logic             serial_data_line_o,
  output logic             serial_data_line_oe_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
    logic [7:0] rx_ctrl;
    logic [7:0] tx_ctrl;
    logic [7:0] irq_en;
    logic [7:0] baud;
    logic [7:0] tx_buf;
    logic       tx_full;
    logic       tx_busy;
    logic [8:0] tx_shift;
    logic [3:0] tx_cnt;
    logic [8:0] rx_shift;
    logic [3:0] rx_cnt;
    logic       overrun;
    logic       clk_lvl;
    logic       dat_out;
    logic       din_s1;
    logic       din_s2;
  } state_t;

  state_t     state_q;
  state_t     state_d;
  logic [7:0] reg_idx;
  logic       req;
  logic       wr_go;
  logic       port_on;
  logic       rx_req;
  logic       tx_en;
  logic       rx_on;
  logic       tx_on;
  logic       brg_run;
  logic       run;
  logic       tick;
  logic       rise;
  logic       fall;
  logic       tx_load;
  logic       tx_flag;
  logic [3:0] tx_bits;
  logic [3:0] rx_bits;
  logic [8:0] rx_new;
  logic [8:0] rx_word;
  logic       rx_done;
  logic       push;
  logic       ovr_set;
  logic       pop;
  logic       fifo_ready;
  logic       fifo_valid;
  logic [8:0] fifo_head;

  // ----------------------------------------------------------------
  // decode of modes
  // ----------------------------------------------------------------
  assign reg_idx = avs_address[9:2];
  assign req     = avs_read | avs_write;
  assign wr_go   = avs_write & state_q.ack & avs_byteenable[0];
  assign port_on = state_q.rx_ctrl[sm_pkg::POS_PORT_EN]
                 & state_q.tx_ctrl[sm_pkg::POS_SYNC_MODE]
                 & state_q.tx_ctrl[sm_pkg::POS_CLK_SRC];
  assign rx_req  = state_q.rx_ctrl[sm_pkg::POS_SINGLE_RX]
                 | state_q.rx_ctrl[sm_pkg::POS_CONT_RX];
  assign tx_en   = state_q.tx_ctrl[sm_pkg::POS_TX_EN];
  assign rx_on   = port_on & rx_req;
  assign tx_on   = port_on & tx_en & ~rx_req;
  assign brg_run = tx_en | rx_req;
  assign run     = rx_on | (tx_on & state_q.tx_busy);
  assign rise    = tick & run & ~state_q.clk_lvl;
  assign fall    = tick & run & state_q.clk_lvl;
  assign tx_load = tx_on & ~state_q.tx_busy & state_q.tx_full;
  assign tx_flag = tx_en & ~state_q.tx_full;
  assign tx_bits = state_q.tx_ctrl[sm_pkg::POS_NINTH_TX_SEL]
                 ? sm_pkg::WORD_BITS_9 : sm_pkg::WORD_BITS_8;
  assign rx_bits = state_q.rx_ctrl[sm_pkg::POS_NINTH_RX_SEL]
                 ? sm_pkg::WORD_BITS_9 : sm_pkg::WORD_BITS_8;

  // ----------------------------------------------------------------
  // receive word assembly, lsb first
  // ----------------------------------------------------------------
  assign rx_new  = {state_q.din_s2, state_q.rx_shift[8:1]};
  assign rx_word = state_q.rx_ctrl[sm_pkg::POS_NINTH_RX_SEL]
                 ? rx_new : {1'b0, rx_new[8:1]};
  assign rx_done = fall & (state_q.rx_cnt + 4'h1 == rx_bits);
  assign push    = rx_done & ~state_q.overrun & fifo_ready;
  assign ovr_set = rx_done & ~state_q.overrun & ~fifo_ready;
  // reading the receive buffer advances the FIFO and its ninth bit
  assign pop     = avs_read & state_q.ack
                 & (reg_idx == sm_pkg::IDX_RX_BUF) & fifo_valid;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest = req & ~state_q.ack;
  assign avs_readdata    = {24'h000000, state_q.rdata};
  assign serial_clock_line_o    = state_q.clk_lvl;
  // clock floats once every enable is gone
  assign serial_clock_line_oe_n = ~(port_on & (tx_en | rx_req));
  assign serial_data_line_o     = state_q.dat_out;
  assign serial_data_line_oe_n  = ~tx_on;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] rd_mux;
    rd_mux = 8'h00;
    state_d = state_q;
    state_d.ack    = req & ~state_q.ack;
    state_d.din_s1 = serial_data_line_i;
    state_d.din_s2 = state_q.din_s1;

    // read data is latched in the wait cycle, stands at the taking edge
    case (reg_idx)
      sm_pkg::IDX_IRQ_FLAGS:
      begin
        rd_mux[sm_pkg::POS_RX_FLAG] = fifo_valid;
        rd_mux[sm_pkg::POS_TX_FLAG] = tx_flag;
      end
      sm_pkg::IDX_RX_CTRL:
      begin
        rd_mux = state_q.rx_ctrl;
        rd_mux[sm_pkg::POS_OVERRUN]  = state_q.overrun;
        rd_mux[sm_pkg::POS_RX_NINTH] = fifo_valid & fifo_head[8];
      end
      sm_pkg::IDX_TX_BUF:
        rd_mux = state_q.tx_buf;
      sm_pkg::IDX_RX_BUF:
        rd_mux = fifo_head[7:0];
      sm_pkg::IDX_IRQ_EN:
        rd_mux = state_q.irq_en;
      sm_pkg::IDX_TX_CTRL:
      begin
        rd_mux = state_q.tx_ctrl;
        rd_mux[sm_pkg::POS_SHIFT_EMPTY] = ~state_q.tx_busy;
      end
      sm_pkg::IDX_BAUD:
        rd_mux = state_q.baud;
      default:
        rd_mux = 8'h00;
    endcase
    if (req && !state_q.ack)
      state_d.rdata = rd_mux;

    // shift clock idles low between words, except in continuous receive
    if (!run)
      state_d.clk_lvl = 1'b0;
    else if (tick)
      state_d.clk_lvl = ~state_q.clk_lvl;

    // transmitter; a receive only freezes it, never resets it
    if (!tx_en)
    begin
      state_d.tx_busy = 1'b0;
      state_d.tx_cnt  = 4'h0;
    end
    else if (tx_load)
    begin
      state_d.tx_shift = {state_q.tx_ctrl[sm_pkg::POS_TX_NINTH],
                          state_q.tx_buf};
      state_d.tx_full  = 1'b0;
      state_d.tx_busy  = 1'b1;
      state_d.tx_cnt   = 4'h0;
    end
    else if (tx_on && rise)
    begin
      state_d.dat_out  = state_q.tx_shift[0];
      state_d.tx_shift = {1'b0, state_q.tx_shift[8:1]};
      state_d.tx_cnt   = state_q.tx_cnt + 4'h1;
    end
    else if (tx_on && fall && state_q.tx_cnt == tx_bits)
      state_d.tx_busy = 1'b0;

    // receiver
    if (!rx_on)
      state_d.rx_cnt = 4'h0;
    else if (fall)
    begin
      state_d.rx_shift = rx_new;
      state_d.rx_cnt   = rx_done ? 4'h0 : state_q.rx_cnt + 4'h1;
      if (rx_done && !state_q.rx_ctrl[sm_pkg::POS_CONT_RX])
        state_d.rx_ctrl[sm_pkg::POS_SINGLE_RX] = 1'b0;
    end

    // register writes, taken at the edge where waitrequest is low
    if (wr_go)
    begin
      case (reg_idx)
        sm_pkg::IDX_RX_CTRL:
        begin
          state_d.rx_ctrl = avs_writedata[7:0] & sm_pkg::RX_CTRL_WMASK;
          if (!avs_writedata[sm_pkg::POS_CONT_RX])
            state_d.overrun = 1'b0;
        end
        sm_pkg::IDX_TX_BUF:
        begin
          state_d.tx_buf  = avs_writedata[7:0];
          state_d.tx_full = 1'b1;
        end
        sm_pkg::IDX_IRQ_EN:
          state_d.irq_en = avs_writedata[7:0];
        sm_pkg::IDX_TX_CTRL:
          state_d.tx_ctrl = avs_writedata[7:0] & sm_pkg::TX_CTRL_WMASK;
        sm_pkg::IDX_BAUD:
          state_d.baud = avs_writedata[7:0];
        default:
          state_d.baud = state_q.baud;
      endcase
    end

    // hardware set wins over a clear in the same cycle
    if (ovr_set)
      state_d.overrun = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  baud_generator #(
    .W       (sm_pkg::BAUD_W)
  ) u_baud (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (brg_run),
    .divisor (state_q.baud),
    .tick    (tick)
  );

  rx_fifo #(
    .WIDTH      (sm_pkg::WORD_W),
    .DEPTH      (sm_pkg::RX_DEPTH)
  ) u_fifo (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .push_valid (push),
    .push_data  (rx_word),
    .push_ready (fifo_ready),
    .pop        (pop),
    .head_valid (fifo_valid),
    .head_data  (fifo_head)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  half_duplex_a: assert property (!(!serial_data_line_oe_n && rx_on))
    else $error("data line driven while receiving");

  pins_released_a: assert property (!state_q.rx_ctrl[sm_pkg::POS_PORT_EN]
    |-> serial_clock_line_oe_n && serial_data_line_oe_n)
    else $error("pins driven with port disabled");

  rx_clock_a: assert property (rx_on |-> !serial_clock_line_oe_n)
    else $error("clock not driven during receive");

  shifter_load_a: assert property (tx_load && !(wr_go && reg_idx == sm_pkg::IDX_TX_BUF)
    |=> state_q.tx_busy && !state_q.tx_full
        && state_q.tx_shift[8] == $past(state_q.tx_ctrl[sm_pkg::POS_TX_NINTH]))
    else $error("buffer to shifter load wrong");

  flag_clear_a: assert property (wr_go && reg_idx == sm_pkg::IDX_TX_BUF |=> !tx_flag)
    else $error("transmit flag not cleared by write");

  data_on_rise_a: assert property ($changed(state_q.dat_out) |-> $rose(state_q.clk_lvl))
    else $error("data changed off a rising edge");

  baud_hold_a: assert property (!brg_run |=> !tick)
    else $error("baud generator ran while idle");

  tx_abort_a: assert property (!tx_en |=> !state_q.tx_busy)
    else $error("transmitter not reset");

  single_done_a: assert property (rx_done && !state_q.rx_ctrl[sm_pkg::POS_CONT_RX] && !wr_go
    |=> !state_q.rx_ctrl[sm_pkg::POS_SINGLE_RX])
    else $error("single receive did not clear");

  fifo_push_a: assert property (push && !pop |=> fifo_valid)
    else $error("word not stored");

  overrun_set_a: assert property (ovr_set |=> state_q.overrun)
    else $error("overrun not flagged");

  overrun_block_a: assert property (state_q.overrun |-> !push)
    else $error("push during overrun");

endmodule

`default_nettype wire

/* File: sim/sync_slave_model.sv */
// far-side synchronous slave: captures driven words, drives words back
`timescale 1ns/100ps
`default_nettype none

module sync_slave_model (
  // system
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // master pins
  input  wire logic        clk_out,
  input  wire logic        clk_oe_n,
  input  wire logic        dat_out,
  input  wire logic        dat_oe_n,
  // bench control
  input  wire logic        clear,
  input  wire logic        drive,
  input  wire logic [35:0] pattern,
  // line level and capture
  output logic             dat_level,
  output logic [35:0]      got,
  output logic [5:0]       n_got,
  output logic [5:0]       n_fall
);
  logic line_q;
  logic last_q;
  // clock line has a pull-down; nobody drives it when released
  wire logic line = clk_oe_n ? 1'b0 : clk_out;

  // floating data shows a toggling level so a stale bit never passes
  assign dat_level = !dat_oe_n ? dat_out : (drive ? pattern[n_fall] : ~last_q);

  always_ff @(posedge clk_sys)
  begin
    line_q <= line;
    // known start, else the toggling released level stays unknown
    last_q <= !rst_n ? 1'b0 : dat_level;
    if (!rst_n || clear)
    begin
      n_fall <= 6'h00;
      n_got  <= 6'h00;
      got    <= 36'h0;
    end
    else if (!line && line_q && !dat_oe_n)
    begin
      got[n_got] <= dat_level;
      n_got      <= n_got + 6'h01;
    end
    // next bit only after the fall, well clear of the master's sample
    else if (!line && line_q)
      n_fall <= (n_fall == 6'h23) ? 6'h00 : n_fall + 6'h01;
  end
endmodule
`default_nettype wire

/* File: sim/usart_sync_master_tb_top.sv */
// self-checking bench for the synchronous master serial port
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end

module usart_sync_master_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  be = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        clk_out, clk_oe_n, dat_out, dat_oe_n, dat_level;
  logic        clear = 1'b0;
  logic        drive = 1'b0;
  logic [35:0] pattern = 36'h0;
  logic [35:0] got, pat;
  logic [5:0]  n_got, n_fall;
  logic [31:0] seed = 32'h00007D2C;
  logic [7:0]  rd, b1, b2;
  logic [7:0]  idx_tab [8] = '{8'h0C, 8'h18, 8'h19, 8'h1A, 8'h8C, 8'h98, 8'h99, 8'h20};
  logic [7:0]  rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  int          n_fail = 0;
  int          n_tests = 0;

  always #10 clk_sys = ~clk_sys;

  usart_sync_master DUT (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_clock_line_o(clk_out), .serial_clock_line_oe_n(clk_oe_n),
    .serial_data_line_i(dat_level), .serial_data_line_o(dat_out),
    .serial_data_line_oe_n(dat_oe_n));

  sync_slave_model slave (.clk_sys(clk_sys), .rst_n(rst_n), .clk_out(clk_out),
    .clk_oe_n(clk_oe_n), .dat_out(dat_out), .dat_oe_n(dat_oe_n), .clear(clear),
    .drive(drive), .pattern(pattern), .dat_level(dat_level), .got(got), .n_got(n_got),
    .n_fall(n_fall));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic tmo(input string nm);
    n_fail++;
    $display("Error %s expected done seen timeout", nm);
    stop_test();
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    k = 0;
    avs_address   <= {idx, 2'b00};
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {24'h0, wd};
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 20);
    if (avs_waitrequest !== 1'b0)
      tmo("waitrequest");
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rreg(input logic [7:0] idx);
    bus(1'b0, idx, 8'h00);
  endtask

  task automatic poll(input logic [7:0] idx, input int b, input logic v);
    int k;
    for (k = 0; k < 300; k++)
    begin
      rreg(idx);
      if (rd[b] === v)
        return;
    end
    tmo("poll");
  endtask

  task automatic wait_bits(input logic [5:0] n);
    int k;
    for (k = 0; k < 3000 && n_got < n; k++)
      @(posedge clk_sys);
    if (n_got < n)
      tmo("bit count");
  endtask

  task automatic clr;
    clear <= 1'b1;
    @(posedge clk_sys);
    clear <= 1'b0;
  endtask

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // ----------------------------------------------------------------
    // register reset values, access kinds, unmapped place
    // ----------------------------------------------------------------
    foreach (idx_tab[j])
    begin
      rreg(idx_tab[j]);
      `CHK("reset value", rst_tab[j], rd)
    end
    seed = xs(seed);
    wreg(sm_pkg::IDX_BAUD, seed[7:0]);
    be <= 4'hE;
    wreg(sm_pkg::IDX_BAUD, ~seed[7:0]);
    be <= 4'hF;
    rreg(sm_pkg::IDX_BAUD);
    `CHK("baud divisor", seed[7:0], rd)
    wreg(sm_pkg::IDX_IRQ_EN, seed[15:8]);
    rreg(sm_pkg::IDX_IRQ_EN);
    `CHK("irq enables", seed[15:8], rd)
    wreg(sm_pkg::IDX_IRQ_FLAGS, 8'hFF);
    wreg(8'h20, 8'hFF);
    rreg(sm_pkg::IDX_IRQ_FLAGS);
    `CHK("irq flags read only", 8'h00, rd)
    wreg(sm_pkg::IDX_TX_CTRL, 8'h0E);
    rreg(sm_pkg::IDX_TX_CTRL);
    `CHK("tx control", 8'h06, rd)
    // ----------------------------------------------------------------
    // master setup: half period 4 cycles, generator idle
    // ----------------------------------------------------------------
    wreg(sm_pkg::IDX_BAUD, 8'h03);
    wreg(sm_pkg::IDX_TX_CTRL, 8'hB0);
    `CHK("port off data float", 1'b1, dat_oe_n)
    `CHK("port off clock float", 1'b1, clk_oe_n)
    wreg(sm_pkg::IDX_RX_CTRL, 8'h80);
    wreg(sm_pkg::IDX_TX_CTRL, 8'h90);
    repeat (20) @(posedge clk_sys);
    `CHK("idle clock", 1'b0, clk_out)
    `CHK("idle clock enable", 1'b1, clk_oe_n)
    // ----------------------------------------------------------------
    // back-to-back transmit, flag and shifter status
    // ----------------------------------------------------------------
    wreg(sm_pkg::IDX_TX_CTRL, 8'hB0);
    rreg(sm_pkg::IDX_IRQ_FLAGS);
    `CHK("tx flag on enable", 8'h10, rd)
    `CHK("clock driven", 1'b0, clk_oe_n)
    clr();
    seed = xs(seed);
    b1 = seed[7:0];
    b2 = seed[15:8];
    wreg(sm_pkg::IDX_TX_BUF, b1);
    wreg(sm_pkg::IDX_TX_BUF, b2);
    rreg(sm_pkg::IDX_IRQ_FLAGS);
    `CHK("tx flag held", 8'h00, rd)
    rreg(sm_pkg::IDX_TX_CTRL);
    `CHK("shifter busy", 1'b0, rd[1])
    wait_bits(6'h10);
    `CHK("first word", b1, got[7:0])
    `CHK("second word", b2, got[15:8])
    poll(sm_pkg::IDX_TX_CTRL, 1, 1'b1);
    rreg(sm_pkg::IDX_IRQ_FLAGS);
    `CHK("tx flag after", 8'h10, rd)
    // ----------------------------------------------------------------
    // ninth bit taken at load, then abort by enable clear
    // ----------------------------------------------------------------
    wreg(sm_pkg::IDX_TX_CTRL, 8'hF1);
    clr();
    wreg(sm_pkg::IDX_TX_BUF, seed[23:16]);
    wreg(sm_pkg::IDX_TX_CTRL, 8'hF0);
    wait_bits(6'h09);
    `CHK("nine bit word", {1'b1, seed[23:16]}, got[8:0])
    clr();
    wreg(sm_pkg::IDX_TX_BUF, seed[31:24]);
    wait_bits(6'h03);
    wreg(sm_pkg::IDX_TX_CTRL, 8'h90);
    `CHK("abort data float", 1'b1, dat_oe_n)
    `CHK("abort clock float", 1'b1, clk_oe_n)
    rreg(sm_pkg::IDX_TX_CTRL);
    `CHK("abort resets shifter", 1'b1, rd[1])
    // ----------------------------------------------------------------
    // single receive breaks into a transmit, then transmit resumes
    // ----------------------------------------------------------------
    wreg(sm_pkg::IDX_TX_CTRL, 8'hB0);
    drive <= 1'b1;
    clr();
    wreg(sm_pkg::IDX_TX_BUF, b2);
    wait_bits(6'h02);
    wreg(sm_pkg::IDX_RX_CTRL, 8'hA0);
    `CHK("rx floats data", 1'b1, dat_oe_n)
    `CHK("rx keeps clock", 1'b0, clk_oe_n)
    poll(sm_pkg::IDX_IRQ_FLAGS, 5, 1'b1);
    rreg(sm_pkg::IDX_RX_CTRL);
    `CHK("single self clear", 1'b0, rd[5])
    `CHK("tx drives again", 1'b0, dat_oe_n)
    rreg(sm_pkg::IDX_RX_BUF);
    wreg(sm_pkg::IDX_TX_CTRL, 8'h90);
    // ----------------------------------------------------------------
    // clean single word, exactly one word clocked
    // ----------------------------------------------------------------
    seed = xs(seed);
    pat = {seed[3:0], seed};
    pattern <= pat;
    clr();
    wreg(sm_pkg::IDX_RX_CTRL, 8'hA0);
    poll(sm_pkg::IDX_IRQ_FLAGS, 5, 1'b1);
    rreg(sm_pkg::IDX_RX_CTRL);
    `CHK("rx status single", 8'h80, rd)
    rreg(sm_pkg::IDX_RX_BUF);
    `CHK("rx word", pat[7:0], rd)
    rreg(sm_pkg::IDX_IRQ_FLAGS);
    `CHK("rx flag cleared", 8'h00, rd)
    repeat (40) @(posedge clk_sys);
    `CHK("one word only", 6'h08, n_fall)
    // ----------------------------------------------------------------
    // continuous nine-bit receive into full FIFO, overrun
    // ----------------------------------------------------------------
    seed = xs(seed);
    pat = {seed[3:0], seed};
    pattern <= pat;
    clr();
    wreg(sm_pkg::IDX_RX_CTRL, 8'hF0);
    poll(sm_pkg::IDX_RX_CTRL, 1, 1'b1);
    `CHK("first ninth", pat[8], rd[0])
    rreg(sm_pkg::IDX_RX_BUF);
    `CHK("fifo first", pat[7:0], rd)
    rreg(sm_pkg::IDX_RX_CTRL);
    `CHK("second ninth", pat[17], rd[0])
    rreg(sm_pkg::IDX_RX_BUF);
    `CHK("fifo second", pat[16:9], rd)
    // two more word times of 9 bits at 8 cycles each
    repeat (160) @(posedge clk_sys);
    rreg(sm_pkg::IDX_IRQ_FLAGS);
    `CHK("overrun blocks push", 8'h00, rd)
    wreg(sm_pkg::IDX_RX_CTRL, 8'hC0);
    rreg(sm_pkg::IDX_RX_CTRL);
    `CHK("overrun cleared", 8'hC0, rd)
    stop_test();
  end
endmodule
`default_nettype wire
